// ### stp_traj.sv
`timescale 1ns/100ps
// Notes on behaviour
// - commanded-position write loads only while the axis is not moving
// - commanded-position write during motion stalls the bus until motion ends, then applies
// - commanded position is signed counts held within plus or minus 2147483647
// - writing commanded position loads measured position with the same value
// - both positions clear to zero at reset
// - drive enable command copies measured position into commanded position
// - end of a homing move loads commanded position with the home value
// - commanded position reads back scaled from counts into user units
// - acceleration write of zero or less is rejected with error code 6
// - acceleration above the maximum is stored as the maximum
// - acceleration resets to half the maximum acceleration
// - acceleration may be written in motion, profiler takes it at next move
// - deceleration write of zero or less is rejected with error code 7
// - deceleration above the maximum is stored as the maximum
// - deceleration resets to half the maximum acceleration
// - deceleration may be written in motion, profiler takes it at next move
// - distance adjust during an index move lengthens or shortens its target
// - shortening behind the current position stops the move
// - distance adjust is ignored while the move is already stopping
// - distance read gives travel magnitude since the last move start
// - status reads one while motion is incomplete, zero once finished
// - switch read returns signed seven digits, strobing general outputs three to six
// - measured position covers plus or minus 2147483647 counts, read in user units
module stp_traj
  import stp_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          enc_step,
  input  wire logic          enc_dir,
  input  wire stp_prof_in_s  prof_i,
  output stp_prof_out_s      prof_o,
  input  wire logic [3:0]    switch_digit,
  output logic [3:0]         switch_strobe_outputs
);

  typedef struct packed {
    stp_state_e    state;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic [31:0]   cmd_pos;
    logic [31:0]   meas_pos;
    logic [31:0]   accel;
    logic [31:0]   decel;
    logic [31:0]   max_accel;
    logic [31:0]   home_pos;
    logic [15:0]   unit;
    logic [7:0]    err;
    logic [31:0]   start_pos;
    logic [3:0]    gp_level;
    logic [3:0]    gp_out;
    logic          div_start;
    logic [31:0]   div_num;
    logic          bcd_start;
    stp_prof_out_s prof;
  } stp_traj_s;

  stp_traj_s   r;
  stp_traj_s   next_r;
  logic        div_done;
  logic [31:0] div_quo;
  logic        bcd_active;
  logic        bcd_done;
  logic [3:0]  bcd_strobe;
  logic [31:0] bcd_value;
  logic        access;
  logic [31:0] wr_counts;

  // user units to counts, saturated so -2^31 never appears
  function automatic logic [31:0] to_counts(input logic [31:0] v, input logic [15:0] u);
    logic signed [48:0] p;
    p = $signed({{17{v[31]}}, v}) * $signed({33'h0_0000_0000, u});
    if (p > $signed({17'h0_0000, POS_MAX})) begin
      return POS_MAX;
    end else if (p < $signed({{17{1'b1}}, POS_MIN})) begin
      return POS_MIN;
    end
    return p[31:0];
  endfunction

  // saturating signed add within the position range
  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
    logic signed [32:0] s;
    s = $signed({a[31], a}) + $signed({b[31], b});
    if (s > $signed({1'b0, POS_MAX})) begin
      return POS_MAX;
    end else if (s < $signed({1'b1, POS_MIN})) begin
      return POS_MIN;
    end
    return s[31:0];
  endfunction

  function automatic logic [31:0] rate_clamp(input logic [31:0] v, input logic [31:0] max);
    return ($signed(v) > $signed(max)) ? max : v;
  endfunction

  assign access    = psel && penable && !r.pready;
  assign wr_counts = to_counts(pwdata, r.unit);

  always_comb begin
    logic [31:0] new_t;
    logic [31:0] diff;
    logic        dir_up;
    new_t = 32'h0000_0000;
    diff = 32'h0000_0000;
    dir_up = 1'b0;
    next_r = r;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.div_start = 1'b0;
    next_r.bcd_start = 1'b0;
    next_r.prof.adj_load = 1'b0;
    next_r.prof.stop_req = 1'b0;
    if (enc_step) begin
      next_r.meas_pos = sat_add(r.meas_pos, enc_dir ? 32'hFFFF_FFFF : 32'h0000_0001);
    end
    if (prof_i.cmd_upd) begin
      next_r.cmd_pos = prof_i.cmd_val;
    end
    if (prof_i.homing_done) begin
      next_r.cmd_pos = r.home_pos;
    end
    if (prof_i.move_start) begin
      // rates written mid-move wait here for the next move
      next_r.prof.accel = r.accel;
      next_r.prof.decel = r.decel;
      next_r.start_pos = r.meas_pos;
    end
    case (r.state)
      ST_IDLE: begin
        if (access && pwrite) begin
          next_r.pready = 1'b1;
          case (paddr)
            OFF_CMD_POS: begin
              if (prof_i.busy) begin
                next_r.pready = 1'b0;
                next_r.state = ST_HOLD;
              end else begin
                next_r.cmd_pos = wr_counts;
                next_r.meas_pos = wr_counts;
              end
            end
            OFF_ACCEL: begin
              if ($signed(pwdata) <= 0) begin
                // first error locks out later ones
                if (r.err == ERR_NONE) begin
                  next_r.err = ERR_ACCEL;
                end
              end else begin
                next_r.accel = rate_clamp(pwdata, r.max_accel);
              end
            end
            OFF_DECEL: begin
              if ($signed(pwdata) <= 0) begin
                if (r.err == ERR_NONE) begin
                  next_r.err = ERR_DECEL;
                end
              end else begin
                next_r.decel = rate_clamp(pwdata, r.max_accel);
              end
            end
            OFF_MAX_ACCEL: begin
              if ($signed(pwdata) > 0) begin
                next_r.max_accel = pwdata;
              end
            end
            OFF_MOVE_DISTANCE_ADJUST: begin
              if (prof_i.index_move && !prof_i.stopping) begin
                dir_up = $signed(prof_i.target) >= $signed(r.start_pos);
                new_t = sat_add(prof_i.target, dir_up ? wr_counts : 32'h0000_0000 - wr_counts);
                if (dir_up ? ($signed(new_t) < $signed(r.meas_pos)) : ($signed(new_t) > $signed(r.meas_pos))) begin
                  next_r.prof.stop_req = 1'b1;
                end else begin
                  next_r.prof.adj_target = new_t;
                  next_r.prof.adj_load = 1'b1;
                end
              end
            end
            OFF_CTRL: begin
              next_r.gp_level = pwdata[CTRL_GP_LSB +: 4];
              if (pwdata[CTRL_DRIVE_EN_BIT]) begin
                next_r.cmd_pos = r.meas_pos;
              end
            end
            OFF_HOME: begin
              next_r.home_pos = wr_counts;
            end
            OFF_UNIT: begin
              // zero would make reads divide by zero
              if (pwdata[15:0] != 16'h0000) begin
                next_r.unit = pwdata[15:0];
              end
            end
            OFF_MEAS_POS, OFF_STATUS, OFF_SWITCH, OFF_ERR: begin
            end
            default: begin
              next_r.pslverr = 1'b1;
            end
          endcase
        end else if (access) begin
          next_r.pready = 1'b1;
          next_r.prdata = 32'h0000_0000;
          case (paddr)
            OFF_CMD_POS, OFF_MEAS_POS, OFF_MOVE_DISTANCE_ADJUST: begin
              next_r.pready = 1'b0;
              next_r.div_start = 1'b1;
              next_r.state = ST_DIV;
              if (paddr == OFF_CMD_POS) begin
                next_r.div_num = r.cmd_pos;
              end else if (paddr == OFF_MEAS_POS) begin
                next_r.div_num = r.meas_pos;
              end else begin
                diff = sat_add(r.meas_pos, 32'h0000_0000 - r.start_pos);
                next_r.div_num = diff[31] ? 32'h0000_0000 - diff : diff;
              end
            end
            OFF_ACCEL:     next_r.prdata = r.accel;
            OFF_DECEL:     next_r.prdata = r.decel;
            OFF_MAX_ACCEL: next_r.prdata = r.max_accel;
            OFF_STATUS:    next_r.prdata = {31'h0000_0000, prof_i.busy};
            OFF_SWITCH: begin
              next_r.pready = 1'b0;
              next_r.bcd_start = 1'b1;
              next_r.state = ST_BCD;
            end
            OFF_ERR: begin
              next_r.prdata = {24'h00_0000, r.err};
              next_r.err = ERR_NONE;
            end
            OFF_CTRL:      next_r.prdata = {27'h000_0000, r.gp_level, 1'b0};
            OFF_HOME:      next_r.prdata = r.home_pos;
            OFF_UNIT:      next_r.prdata = {16'h0000, r.unit};
            default:       next_r.pslverr = 1'b1;
          endcase
        end
      end
      ST_DIV: begin
        if (div_done) begin
          next_r.prdata = div_quo;
          next_r.pready = 1'b1;
          next_r.state = ST_IDLE;
        end
      end
      ST_BCD: begin
        if (bcd_done) begin
          next_r.prdata = bcd_value;
          next_r.pready = 1'b1;
          next_r.state = ST_IDLE;
        end
      end
      ST_HOLD: begin
        // master holds pwdata, so it is applied once motion ends
        if (!prof_i.busy) begin
          next_r.cmd_pos = wr_counts;
          next_r.meas_pos = wr_counts;
          next_r.pready = 1'b1;
          next_r.state = ST_IDLE;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
    next_r.gp_out = bcd_active ? bcd_strobe : next_r.gp_level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.accel <= ACCEL_RST;
      r.decel <= ACCEL_RST;
      r.max_accel <= MAX_ACCEL_RST;
      r.home_pos <= HOME_RST;
      r.unit <= UNIT_RST;
      r.prof.accel <= ACCEL_RST;
      r.prof.decel <= ACCEL_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  stp_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start   (r.div_start),
    .num     (r.div_num),
    .den     (r.unit),
    .done    (div_done),
    .quo     (div_quo)
  );

  stp_bcd u_bcd (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .start     (r.bcd_start),
    .digit_pin (switch_digit),
    .strobe    (bcd_strobe),
    .active    (bcd_active),
    .done      (bcd_done),
    .value     (bcd_value)
  );

  assign prdata                = r.prdata;
  assign pready                = r.pready;
  assign pslverr               = r.pslverr;
  assign prof_o                = r.prof;
  assign switch_strobe_outputs = r.gp_out;

  logic wr_now;
  assign wr_now = ce && access && pwrite && r.state == ST_IDLE;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hold_release;
    r.state == ST_HOLD && !prof_i.busy && ce;
  endsequence

  hold_stall_a: assert property (r.state == ST_HOLD && prof_i.busy |=> !r.pready)
    else $error("pready rose while the axis was moving");
  hold_apply_a: assert property (s_hold_release |=> r.pready && r.cmd_pos == r.meas_pos)
    else $error("held position write not applied after motion");
  pos_load_a: assert property (wr_now && paddr == OFF_CMD_POS && !prof_i.busy
                               |=> r.cmd_pos == r.meas_pos && r.cmd_pos == $past(wr_counts))
    else $error("measured position not loaded with commanded");
  pos_range_a: assert property (r.cmd_pos != 32'h8000_0000 && r.meas_pos != 32'h8000_0000)
    else $error("position left its range");
  accel_err_a: assert property (wr_now && paddr == OFF_ACCEL && $signed(pwdata) <= 0 && r.err == ERR_NONE
                                |=> r.err == ERR_ACCEL && $stable(r.accel))
    else $error("bad acceleration not rejected");
  decel_err_a: assert property (wr_now && paddr == OFF_DECEL && $signed(pwdata) <= 0 && r.err == ERR_NONE
                                |=> r.err == ERR_DECEL && $stable(r.decel))
    else $error("bad deceleration not rejected");
  accel_clamp_a: assert property (wr_now && paddr == OFF_ACCEL && $signed(pwdata) > $signed(r.max_accel)
                                  |=> r.accel == $past(r.max_accel))
    else $error("acceleration not clamped");
  rate_latch_a: assert property (!(ce && prof_i.move_start) |=> $stable(r.prof.accel) && $stable(r.prof.decel))
    else $error("profiler rates changed outside a move start");
  move_distance_adjust_stop_a: assert property (wr_now && paddr == OFF_MOVE_DISTANCE_ADJUST && prof_i.stopping
                                |=> !r.prof.adj_load && !r.prof.stop_req)
    else $error("distance adjust acted while stopping");
  drive_en_a: assert property (wr_now && paddr == OFF_CTRL && pwdata[CTRL_DRIVE_EN_BIT]
                               |=> r.cmd_pos == $past(r.meas_pos))
    else $error("drive enable did not copy measured position");
  status_rd_a: assert property (wr_now == 1'b0 && ce && access && !pwrite && r.state == ST_IDLE && paddr == OFF_STATUS
                                |=> r.pready && r.prdata == {31'h0000_0000, $past(prof_i.busy)})
    else $error("status read does not show motion");
  pos_read_a: assert property (ce && access && !pwrite && r.state == ST_IDLE && paddr == OFF_CMD_POS
                               |-> ##[1:40] r.pready)
    else $error("scaled read did not answer in time");

endmodule // stp_traj

// ### stp_pkg.sv
package stp_pkg;

  // register byte offsets on the APB port
  localparam logic [11:0] OFF_CMD_POS   = 12'h000;
  localparam logic [11:0] OFF_MEAS_POS  = 12'h004;
  localparam logic [11:0] OFF_ACCEL     = 12'h008;
  localparam logic [11:0] OFF_DECEL     = 12'h00C;
  localparam logic [11:0] OFF_MAX_ACCEL = 12'h010;
  localparam logic [11:0] OFF_MOVE_DISTANCE_ADJUST      = 12'h014;
  localparam logic [11:0] OFF_STATUS    = 12'h018;
  localparam logic [11:0] OFF_SWITCH    = 12'h01C;
  localparam logic [11:0] OFF_ERR       = 12'h020;
  localparam logic [11:0] OFF_CTRL      = 12'h024;
  localparam logic [11:0] OFF_HOME      = 12'h028;
  localparam logic [11:0] OFF_UNIT      = 12'h02C;

  // control register fields
  localparam int CTRL_DRIVE_EN_BIT = 0;
  localparam int CTRL_GP_LSB       = 1;

  localparam logic [31:0] POS_MAX       = 32'h7FFF_FFFF;
  localparam logic [31:0] POS_MIN       = 32'h8000_0001;
  localparam logic [31:0] MAX_ACCEL_RST = 32'h0001_0000;
  localparam logic [31:0] ACCEL_RST     = MAX_ACCEL_RST >> 1;
  localparam logic [31:0] HOME_RST      = 32'h0000_0000;
  localparam logic [15:0] UNIT_RST      = 16'h0001;
  localparam logic [7:0]  ERR_NONE      = 8'h00;
  localparam logic [7:0]  ERR_ACCEL     = 8'h06;
  localparam logic [7:0]  ERR_DECEL     = 8'h07;

  // switch bank scan timing and sign digit, then the divider's last step
  localparam int CLK_PERIOD_NS    = 5;
  localparam int STROBE_SETTLE_NS = 10000;
  localparam int SETTLE_CYC       = (STROBE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SIGN_DIGIT = 3'h7;
  localparam logic [5:0] DIV_LAST   = 6'h1F;

  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_BCD, ST_HOLD} stp_state_e;

  typedef struct packed {
    logic        busy;
    logic        stopping;
    logic        index_move;
    logic        move_start;
    logic        homing_done;
    logic        cmd_upd;
    logic [31:0] cmd_val;
    logic [31:0] target;
  } stp_prof_in_s;

  typedef struct packed {
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] adj_target;
    logic        adj_load;
    logic        stop_req;
  } stp_prof_out_s;

endpackage

// ### stp_div.sv
`timescale 1ns/100ps
module stp_div
  import stp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [31:0] num,
  input  wire logic [15:0] den,
  output logic             done,
  output logic [31:0]      quo
);

  typedef struct packed {
    logic        busy;
    logic        neg;
    logic        done;
    logic [5:0]  cnt;
    logic [16:0] rem;
    logic [31:0] quo;
  } stp_div_s;

  stp_div_s r;
  stp_div_s next_r;

  // restoring division on the magnitude, sign put back at the end
  always_comb begin
    logic [16:0] sh;
    logic [31:0] q;
    sh = 17'h0_0000;
    q = 32'h0000_0000;
    next_r = r;
    next_r.done = 1'b0;
    if (start) begin
      next_r.busy = 1'b1;
      next_r.cnt = 6'h00;
      next_r.rem = 17'h0_0000;
      next_r.neg = num[31];
      next_r.quo = num[31] ? 32'h0000_0000 - num : num;
    end else if (r.busy) begin
      sh = {r.rem[15:0], r.quo[31]};
      q = {r.quo[30:0], 1'b0};
      if (sh >= {1'b0, den}) begin
        sh = sh - {1'b0, den};
        q[0] = 1'b1;
      end
      next_r.rem = sh;
      next_r.quo = q;
      next_r.cnt = r.cnt + 6'h01;
      if (r.cnt == DIV_LAST) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.quo = r.neg ? 32'h0000_0000 - q : q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign quo  = r.quo;

endmodule // stp_div

// ### stp_bcd.sv
`timescale 1ns/100ps
module stp_bcd
  import stp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [3:0]  digit_pin,
  output logic [3:0]       strobe,
  output logic             active,
  output logic             done,
  output logic [31:0]      value
);

  typedef struct packed {
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic        active;
    logic        done;
    logic [2:0]  idx;
    logic [10:0] cnt;
    logic [23:0] acc;
    logic [3:0]  strobe;
    logic [31:0] value;
  } stp_bcd_s;

  stp_bcd_s r;
  stp_bcd_s next_r;

  // seven digits most significant first, then the sign digit
  always_comb begin
    logic [3:0] d;
    d = (r.sync2 > 4'h9) ? 4'h9 : r.sync2;
    next_r = r;
    next_r.sync1 = digit_pin;
    next_r.sync2 = r.sync1;
    next_r.done = 1'b0;
    if (start && !r.active) begin
      next_r.active = 1'b1;
      next_r.idx = 3'h0;
      next_r.cnt = 11'h000;
      next_r.acc = 24'h00_0000;
      next_r.strobe = 4'h8;
    end else if (r.active) begin
      if (r.cnt == 11'(SETTLE_CYC - 1)) begin
        next_r.cnt = 11'h000;
        if (r.idx == SIGN_DIGIT) begin
          next_r.active = 1'b0;
          next_r.done = 1'b1;
          next_r.strobe = 4'h0;
          next_r.value = (r.sync2 != 4'h0) ? 32'h0000_0000 - {8'h00, r.acc} : {8'h00, r.acc};
        end else begin
          next_r.acc = {r.acc[20:0], 3'h0} + {r.acc[22:0], 1'b0} + {20'h0_0000, d};
          next_r.idx = r.idx + 3'h1;
          next_r.strobe = {1'b1, r.idx + 3'h1};
        end
      end else begin
        next_r.cnt = r.cnt + 11'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign strobe = r.strobe;
  assign active = r.active;
  assign done   = r.done;
  assign value  = r.value;

endmodule // stp_bcd

// ### stp_prof_model.sv
`timescale 1ns/100ps
module stp_prof_model
  import stp_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          go,
  input  wire logic [31:0]   len,
  input  wire logic          home,
  input  wire logic [3:0]    strobe,
  input  wire stp_prof_out_s prof_o,
  output stp_prof_in_s       prof_i,
  output logic               enc_step,
  output logic [3:0]         digit
);
  logic [31:0] cnt;
  logic [31:0] tgt;
  logic        go_q;

  // remaining counts of the move; the end point starts at len from a zero origin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      tgt  <= '0;
      go_q <= 1'b0;
    end else begin
      go_q <= go;
      if (go) begin
        cnt <= len;
        tgt <= len;
      end else if (prof_o.stop_req) begin
        // ramp down over a short tail instead of halting dead
        cnt <= (cnt > 32'h8) ? 32'h8 : cnt;
      end else if (prof_o.adj_load) begin
        cnt <= cnt + prof_o.adj_target - tgt;
        tgt <= prof_o.adj_target;
      end else if (cnt != '0) begin
        cnt <= cnt - 32'h1;
      end
    end
  end

  assign enc_step = (cnt != '0);
  assign prof_i   = '{busy: cnt != '0, stopping: (cnt != '0) && (cnt <= 32'h8), index_move: cnt != '0,
                      move_start: go_q, homing_done: home, cmd_upd: 1'b0, cmd_val: '0, target: tgt};

  // switch bank reads -1234567: digits one to seven, nonzero sign digit
  assign digit = !strobe[3] ? 4'h0 : (strobe[2:0] == 3'h7) ? 4'h1 : {1'b0, strobe[2:0] + 3'h1};
endmodule // stp_prof_model

// ### stp_traj_tb.sv
`timescale 1ns/100ps
module stp_traj_tb;
  import stp_pkg::*;
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic          go;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic [31:0]   len;
  logic [31:0]   v;
  logic [31:0]   x;
  logic [31:0]   adj_v;
  logic          pready;
  logic          pslverr;
  logic          enc_step;
  logic          home;
  logic [3:0]    so;
  logic [3:0]    digit;
  stp_prof_in_s  prof_i;
  stp_prof_out_s prof_o;
  logic [33:0]   expq[$];
  logic [33:0]   e;
  int            error_cnt = 0;
  int            cmp_count = 0;
  int            adj_n = 0;
  int            stop_n = 0;
  integer        seed = 32'hF816592E;

  stp_traj dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                .pslverr, .enc_step, .enc_dir(1'b0), .prof_i, .prof_o, .switch_digit(digit),
                .switch_strobe_outputs(so));
  stp_prof_model prof (.pclk, .presetn, .go, .len, .home, .strobe(so), .prof_o, .prof_i, .enc_step, .digit);

  always #2.5 pclk = ~pclk;

  task chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // write expectations carry zero data; only the error flag is compared
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] ex);
    expq.push_back({w, ex});
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task move(input logic [31:0] l);
    @(posedge pclk);
    go  <= 1'b1;
    len <= l;
    @(posedge pclk);
    go  <= 1'b0;
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = expq.pop_front();
      chk({pslverr, e[33] ? 32'h0 : prdata}, e[32:0]);
    end
    if (prof_o.adj_load === 1'b1) begin
      adj_n++;
      adj_v = prof_o.adj_target;
    end
    if (prof_o.stop_req === 1'b1) stop_n++;
  end

  initial begin
    // a switch read alone takes about sixteen thousand cycles
    repeat (30000) @(posedge pclk);
    error_cnt++;
    results;
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, go, home, paddr, pwdata, len} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_CMD_POS, 0, '0);
    apb(0, OFF_MEAS_POS, 0, '0);
    apb(0, OFF_ACCEL, 0, {1'b0, ACCEL_RST});
    apb(0, OFF_DECEL, 0, {1'b0, ACCEL_RST});
    apb(0, OFF_STATUS, 0, '0);
    $display("test reset values done");
    apb(1, OFF_ACCEL, 0, '0);
    apb(0, OFF_ERR, 0, {25'h0, ERR_ACCEL});
    apb(0, OFF_ACCEL, 0, {1'b0, ACCEL_RST});
    apb(1, OFF_DECEL, 32'hFFFF_FFFF, '0);
    apb(0, OFF_ERR, 0, {25'h0, ERR_DECEL});
    apb(0, OFF_DECEL, 0, {1'b0, ACCEL_RST});
    apb(1, OFF_ACCEL, 32'h0002_0000, '0);
    apb(0, OFF_ACCEL, 0, {1'b0, MAX_ACCEL_RST});
    apb(1, OFF_DECEL, 32'h0002_0000, '0);
    apb(0, OFF_DECEL, 0, {1'b0, MAX_ACCEL_RST});
    v = 32'h1 + ($random(seed) & 32'hFFFF);
    apb(1, OFF_ACCEL, v, '0);
    apb(0, OFF_ACCEL, 0, {1'b0, v});
    apb(1, 12'h0FC, 0, {1'b1, 32'h0});
    $display("test rates done");
    x = $random(seed) & 32'h3FFF_FFFF;
    apb(1, OFF_CMD_POS, x, '0);
    apb(0, OFF_CMD_POS, 0, {1'b0, x});
    apb(0, OFF_MEAS_POS, 0, {1'b0, x});
    apb(1, OFF_UNIT, 32'h4, '0);
    apb(0, OFF_CMD_POS, 0, {1'b0, x >> 2});
    apb(0, OFF_MEAS_POS, 0, {1'b0, x >> 2});
    apb(1, OFF_UNIT, 32'h1, '0);
    $display("test positions done");
    move(32'd40);
    apb(0, OFF_STATUS, 0, {1'b0, 32'h1});
    chk({1'b0, prof_o.accel}, {1'b0, v});
    apb(1, OFF_ACCEL, 32'h100, '0);
    chk({1'b0, prof_o.accel}, {1'b0, v});
    apb(1, OFF_CMD_POS, x, '0);
    chk({32'h0, prof_i.busy}, '0);
    apb(0, OFF_MEAS_POS, 0, {1'b0, x});
    apb(0, OFF_STATUS, 0, '0);
    move(32'd10);
    repeat (20) @(posedge pclk);
    chk({1'b0, prof_o.accel}, {1'b0, 32'h100});
    apb(0, OFF_MOVE_DISTANCE_ADJUST, 0, {1'b0, 32'd10});
    apb(1, OFF_CTRL, 32'h1F, '0);
    chk({29'h0, so}, 33'hF);
    apb(0, OFF_CMD_POS, 0, {1'b0, x + 32'd10});
    $display("test motion done");
    apb(1, OFF_HOME, 32'h0000_0123, '0);
    home <= 1'b1;
    @(posedge pclk);
    home <= 1'b0;
    apb(0, OFF_CMD_POS, 0, {1'b0, 32'h0000_0123});
    $display("test homing done");
    apb(1, OFF_CMD_POS, 0, '0);
    move(32'd50);
    apb(1, OFF_MOVE_DISTANCE_ADJUST, 32'd10, '0);
    // let the monitor count the pulse of the pready edge first
    @(posedge pclk);
    chk(33'(adj_n), 33'd1);
    chk({1'b0, adj_v}, {1'b0, 32'd60});
    apb(1, OFF_MOVE_DISTANCE_ADJUST, -32'd1000, '0);
    @(posedge pclk);
    chk(33'(stop_n), 33'd1);
    apb(1, OFF_MOVE_DISTANCE_ADJUST, 32'd5, '0);
    @(posedge pclk);
    chk(33'(adj_n + stop_n), 33'd2);
    repeat (12) @(posedge pclk);
    $display("test distance done");
    apb(0, OFF_SWITCH, 0, {1'b0, 32'hFFED_2979});
    chk({29'h0, so}, 33'hF);
    $display("test switch done");
    results;
  end
endmodule // stp_traj_tb
